// ===== ufc_pkg.sv
package ufc_pkg;
    // Device register map
    localparam logic [7:0] UFC_CFG_OFS = 8'hC4;
    localparam logic [7:0] UFC_IRQ_OFS = 8'hC8;
    localparam logic [7:0] UFC_UDATA_OFS = 8'hCC;
    localparam logic [7:0] UFC_MASK_OFS = 8'hD0;
    // Configuration register fields
    localparam int UFC_B_INIT_ST = 21;
    localparam int UFC_B_DONE = 20;
    localparam int UFC_B_PROG = 19;
    localparam int UFC_B_INIT = 18;
    localparam int UFC_B_CCLK_EN = 17;
    localparam int UFC_B_SDATA = 16;
    localparam int UFC_B_GIE = 15;
    localparam int UFC_B_UIE = 14;
    localparam int UFC_B_FIFO = 8;
    localparam int UFC_IDX_W = 7;
    localparam logic [31:0] UFC_CFG_WMASK = 32'h000FC17F;
    localparam logic [31:0] UFC_CFG_RESET = 32'h00000000;
    // Interrupt status fields
    localparam int UFC_B_HOST_IRQ = 15;
    localparam int UFC_B_UIRQ = 13;
    localparam int UFC_B_DIRQ = 12;
    // Device access timing, in clocks
    localparam logic [2:0] UFC_CCLK_CYC = 3'h4;
    localparam logic [2:0] UFC_URD_LAT = 3'h3;
    // Sequencer timing
    localparam int UFC_CLK_NS = 20;
    localparam int UFC_WAIT_US = 4;
    localparam int UFC_WAIT_CYC = (UFC_WAIT_US * 1000 + UFC_CLK_NS - 1) / UFC_CLK_NS;
    localparam logic [5:0] UFC_FLUSH_MAX = 6'h20;
    localparam logic [2:0] UFC_CMD_EN_BIT = 3'h3;
    localparam logic [6:0] UFC_CMD_REG = 7'h00;
    // Controller register map
    localparam logic [7:0] UFC_H_CTRL = 8'h00;
    localparam logic [7:0] UFC_H_STAT = 8'h04;
    localparam logic [7:0] UFC_H_DATA = 8'h08;
    localparam logic [7:0] UFC_H_ISTS = 8'h0C;
    localparam logic [7:0] UFC_H_IMSK = 8'h10;
    localparam logic [1:0] UFC_RESP_OK = 2'h0;
    localparam logic [1:0] UFC_RESP_ERR = 2'h2;
endpackage

// ===== ufc_if.sv
`timescale 1ns/1ps
interface ufc_if (
    input wire logic clk
);
    logic req_wr;
    logic req_rd;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic ack;
    logic host_irq;
    modport dev (input clk, input req_wr, input req_rd, input addr, input wdata,
                 output rdata, output ack, output host_irq);
    modport host (input clk, output req_wr, output req_rd, output addr, output wdata,
                  input rdata, input ack, input host_irq);
endinterface

// ===== ufc_dev.sv
`timescale 1ns/1ps
// Summary of operation
// [RQ1] Software lowers program and init controls first
// [RQ2] Then waits for done status low
// [RQ3] Raises controls, polls init status high
// [RQ4] Waits four microseconds before clocking data
// [RQ5] Each write forwards one serial bitstream bit
// [RQ6] After bitstream, writes ones until done high
// [RQ7] Done missing after 32 clocks means failure
// [RQ8] Init pin level readable, writes ignored
// [RQ9] Done reflected; program, init pins from bits
// [RQ10] User interrupt passes only while enabled
// [RQ11] Pulse command enable before enabling FIFO
// [RQ12] Burst FIFO enabled only while bit set
// [RQ13] Seven-bit index selects user FPGA register
// [RQ14] Host interrupt needs user and global enable
// [RQ15] DMA interrupt needs global enable
// [RQ16] Byte access through data register using index
// [RQ17] One configuration clock pulse per write
// [RQ18] Unused bits read zero, ignore writes
module ufc_dev (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Register port
    ufc_if.dev bus,
    // User FPGA configuration pins
    output logic prog_o,
    output logic init_o,
    output logic init_oe_n,
    input wire logic init_i,
    input wire logic done_i,
    output logic cclk_o,
    output logic din_o,
    // User FPGA interrupt and data path
    input wire logic uirq_i,
    input wire logic dma_irq,
    output logic fifo_en,
    output logic [ufc_pkg::UFC_IDX_W-1:0] ureg_addr,
    output logic ureg_wr,
    output logic ureg_rd,
    output logic [7:0] ureg_wdata,
    input wire logic [7:0] ureg_rdata_i
);
    import ufc_pkg::*;

    logic [31:0] cfg_q;
    logic [2:0] cnt_q;
    logic cclk_run_q;
    logic rd_udata_q;
    logic [7:0] addr_q;
    logic [31:0] rdata_q;
    logic [1:0] sts_q;
    logic [1:0] msk_q;
    logic irq_q;
    logic [1:0] init_s_q, done_s_q, uirq_s_q;
    logic [7:0] urd_m_q, urd_s_q;
    logic uirq_d_q, dma_d_q;
    logic [1:0] ev;
    logic [1:0] gate;
    logic take;
    logic [7:0] rsel;

    // A request is only taken while no earlier one is running
    assign take = (bus.req_wr | bus.req_rd) & (cnt_q == 3'h0) & ce;
    assign bus.ack = (cnt_q == 3'h1);
    assign bus.rdata = rdata_q;
    assign bus.host_irq = irq_q;
    assign rsel = take ? bus.addr : addr_q; // New address at the take edge, so one-cycle answers are fresh

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            init_s_q <= 2'h0;
            done_s_q <= 2'h0;
            uirq_s_q <= 2'h0;
            urd_m_q <= 8'h00;
            urd_s_q <= 8'h00;
        end
        else if (ce)
        begin
            init_s_q <= {init_s_q[0], init_i};
            done_s_q <= {done_s_q[0], done_i};
            uirq_s_q <= {uirq_s_q[0], uirq_i};
            urd_m_q <= ureg_rdata_i;
            urd_s_q <= urd_m_q;
        end
    end

    // Configuration register; read-only and unused bits masked off
    always_ff @(posedge clk)
    begin
        if (srst)
            cfg_q <= UFC_CFG_RESET;
        else if (take && bus.req_wr && bus.addr == UFC_CFG_OFS)
            cfg_q <= bus.wdata & UFC_CFG_WMASK; // see [RQ8] see [RQ18]
    end

    // Access timer: one cycle for plain accesses, longer for clocking and user data reads
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cnt_q <= 3'h0;
            cclk_run_q <= 1'b0;
            rd_udata_q <= 1'b0;
            addr_q <= 8'h00;
        end
        else if (ce)
        begin
            if (take)
            begin
                addr_q <= bus.addr;
                rd_udata_q <= bus.req_rd && bus.addr == UFC_UDATA_OFS;
                // Data bit lands now, clock pulse follows once it has settled
                cclk_run_q <= bus.req_wr && bus.addr == UFC_CFG_OFS && bus.wdata[UFC_B_CCLK_EN]; // see [RQ5]
                if (bus.req_wr && bus.addr == UFC_CFG_OFS && bus.wdata[UFC_B_CCLK_EN])
                    cnt_q <= UFC_CCLK_CYC; // see [RQ17]
                else if (bus.req_rd && bus.addr == UFC_UDATA_OFS)
                    cnt_q <= UFC_URD_LAT; // see [RQ16]
                else
                    cnt_q <= 3'h1;
            end
            else if (cnt_q != 3'h0)
                cnt_q <= cnt_q - 3'h1;
        end
    end

    // One clock pulse per bit write, high while data is stable on both sides
    always_ff @(posedge clk)
    begin
        if (srst)
            cclk_o <= 1'b0;
        else if (ce)
            cclk_o <= cclk_run_q && (cnt_q == 3'h3 || cnt_q == 3'h2); // see [RQ17]
    end

    // Read data follows the latched address every cycle until the answer
    always_ff @(posedge clk)
    begin
        if (srst)
            rdata_q <= 32'h00000000;
        else if (ce)
        begin
            case (rsel)
                UFC_CFG_OFS:
                    rdata_q <= {10'h000, init_s_q[1], done_s_q[1], cfg_q[19:0]}; // see [RQ8] see [RQ9]
                UFC_IRQ_OFS:
                    rdata_q <= {16'h0000, irq_q, 1'b0, sts_q, 12'h000};
                UFC_MASK_OFS:
                    rdata_q <= {18'h00000, msk_q, 12'h000};
                UFC_UDATA_OFS:
                    rdata_q <= {24'h000000, urd_s_q}; // see [RQ16]
                default:
                    rdata_q <= 32'h00000000;
            endcase
        end
    end

    // Indirect byte access to the user FPGA at the held index
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ureg_wr <= 1'b0;
            ureg_wdata <= 8'h00;
        end
        else if (ce)
        begin
            ureg_wr <= take && bus.req_wr && bus.addr == UFC_UDATA_OFS; // see [RQ16]
            if (take && bus.req_wr && bus.addr == UFC_UDATA_OFS)
                ureg_wdata <= bus.wdata[7:0];
        end
    end
    assign ureg_rd = rd_udata_q & (cnt_q != 3'h0);
    assign ureg_addr = cfg_q[UFC_IDX_W-1:0]; // see [RQ13]

    // Pin drive straight from the control bits
    assign prog_o = cfg_q[UFC_B_PROG]; // see [RQ9]
    assign init_o = 1'b0;
    // Open drain: pulled low only while the control bit is clear
    assign init_oe_n = cfg_q[UFC_B_INIT]; // see [RQ9]
    assign din_o = cfg_q[UFC_B_SDATA]; // see [RQ5]
    assign fifo_en = cfg_q[UFC_B_FIFO]; // see [RQ12]

    // Interrupt events: rising edges of user and DMA requests
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            uirq_d_q <= 1'b0;
            dma_d_q <= 1'b0;
        end
        else if (ce)
        begin
            uirq_d_q <= uirq_s_q[1];
            dma_d_q <= dma_irq;
        end
    end
    assign ev = {uirq_s_q[1] & ~uirq_d_q, dma_irq & ~dma_d_q};

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge clk)
    begin
        if (srst)
            sts_q <= 2'h0;
        else if (ce)
        begin
            if (take && bus.req_wr && bus.addr == UFC_IRQ_OFS)
                sts_q <= (sts_q & ~bus.wdata[UFC_B_UIRQ:UFC_B_DIRQ]) | ev;
            else
                sts_q <= sts_q | ev;
        end
    end

    // Mask register, same layout as status
    always_ff @(posedge clk)
    begin
        if (srst)
            msk_q <= 2'h0;
        else if (take && bus.req_wr && bus.addr == UFC_MASK_OFS)
            msk_q <= bus.wdata[UFC_B_UIRQ:UFC_B_DIRQ];
    end

    // Host interrupt: user source needs both enables, DMA only the global one
    assign gate = {cfg_q[UFC_B_UIE] & cfg_q[UFC_B_GIE], cfg_q[UFC_B_GIE]}; // see [RQ10] see [RQ14] see [RQ15]
    always_ff @(posedge clk)
    begin
        if (srst)
            irq_q <= 1'b0;
        else if (ce)
            irq_q <= |(sts_q & msk_q & gate); // see [RQ14] see [RQ15]
    end
endmodule

// ===== ufc_host.sv
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module ufc_host (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Device register port
    ufc_if.host dev,
    // AXI4-Lite slave
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Interrupt
    output logic irq
);
    import ufc_pkg::*;

    typedef enum {S_IDLE, S_MASK, S_PROG_LO, S_POLL_DONE, S_PROG_HI, S_POLL_INIT, S_WAIT, S_SHIFT,
                  S_FLUSH_WR, S_FLUSH_RD, S_IDX, S_CMD_SET, S_CMD_CLR, S_FIFO} ufc_state_t;
    ufc_state_t st_q, st_d;
    logic [7:0] aw_q;
    logic aw_ok_q, w_ok_q;
    logic [31:0] wd_q;
    logic [3:0] ctrl_q;
    logic [31:0] word_q;
    logic pend_q, busy_q;
    logic [4:0] bit_q;
    logic [5:0] fl_q;
    logic [7:0] wait_q;
    logic [1:0] ists_q, imsk_q, ev;
    logic req_q, op_wr, op_act, wr_go;
    logic [7:0] op_addr;
    logic [31:0] op_data, base;

    // AXI write: address and data taken in either order, answered together
    assign awready = ~aw_ok_q & ~bvalid;
    assign wready = ~w_ok_q & ~bvalid;
    assign arready = ~rvalid;
    assign wr_go = aw_ok_q & w_ok_q & ~bvalid & ce;
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            aw_ok_q <= 1'b0;
            w_ok_q <= 1'b0;
            aw_q <= 8'h00;
            wd_q <= 32'h00000000;
            bvalid <= 1'b0;
            bresp <= UFC_RESP_OK;
        end
        else if (ce)
        begin
            if (awvalid && awready)
            begin
                aw_ok_q <= 1'b1;
                aw_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_ok_q <= 1'b1;
                // Partial writes store zero data; registers need all four lanes
                wd_q <= (wstrb == 4'hF) ? wdata : 32'h00000000;
            end
            if (wr_go)
            begin
                aw_ok_q <= 1'b0;
                w_ok_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (aw_q <= UFC_H_IMSK && aw_q[1:0] == 2'h0) ? UFC_RESP_OK : UFC_RESP_ERR;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    // AXI read
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= UFC_RESP_OK;
        end
        else if (ce)
        begin
            if (arvalid && arready)
            begin
                rvalid <= 1'b1;
                rresp <= UFC_RESP_OK;
                case (araddr)
                    UFC_H_CTRL: rdata <= {28'h0000000, ctrl_q};
                    UFC_H_STAT: rdata <= {29'h00000000, dev.host_irq, pend_q, busy_q};
                    UFC_H_ISTS: rdata <= {30'h00000000, ists_q};
                    UFC_H_IMSK: rdata <= {30'h00000000, imsk_q};
                    UFC_H_DATA: rdata <= word_q;
                    default:
                    begin
                        rdata <= 32'h00000000;
                        rresp <= UFC_RESP_ERR;
                    end
                endcase
            end
            else if (rvalid && rready)
                rvalid <= 1'b0;
        end
    end

    // Control bits: [1] last word, [2] user irq enable, [3] global irq enable
    always_ff @(posedge clk)
    begin
        if (srst)
            ctrl_q <= 4'h0;
        else if (wr_go && aw_q == UFC_H_CTRL)
            ctrl_q <= {wd_q[3:1], 1'b0};
    end
    assign base = {16'h0000, ctrl_q[3], ctrl_q[2], 14'h0000};

    // Register access the current step needs
    always_comb
    begin
        op_act = 1'b1;
        op_wr = 1'b1;
        op_addr = UFC_CFG_OFS;
        op_data = base;
        case (st_q)
            S_MASK:
            begin
                op_addr = UFC_MASK_OFS; // Unmask both device events
                op_data = 32'h00000003 << UFC_B_DIRQ;
            end
            S_PROG_LO: op_data = base; // see [RQ1]
            S_POLL_DONE: op_wr = 1'b0;
            S_PROG_HI: op_data = base | 32'h000C0000; // see [RQ3]
            S_POLL_INIT: op_wr = 1'b0;
            S_SHIFT:
            begin
                op_act = pend_q;
                op_data = base | 32'h000E0000 | {15'h0000, word_q[31], 16'h0000}; // see [RQ5]
            end
            S_FLUSH_WR: op_data = base | 32'h000F0000; // see [RQ6]
            S_FLUSH_RD: op_wr = 1'b0;
            S_IDX: op_data = base | 32'h000C0000 | {25'h0000000, UFC_CMD_REG};
            S_CMD_SET:
            begin
                op_addr = UFC_UDATA_OFS;
                op_data = 32'h00000001 << UFC_CMD_EN_BIT; // see [RQ11]
            end
            S_CMD_CLR:
            begin
                op_addr = UFC_UDATA_OFS;
                op_data = 32'h00000000;
            end
            S_FIFO: op_data = base | 32'h000C0100 | {25'h0000000, UFC_CMD_REG}; // see [RQ11]
            default: op_act = 1'b0;
        endcase
    end

    // Next step once the device has answered
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            S_MASK: st_d = S_PROG_LO;
            S_PROG_LO: st_d = S_POLL_DONE;
            S_POLL_DONE: st_d = dev.rdata[UFC_B_DONE] ? S_POLL_DONE : S_PROG_HI; // see [RQ2]
            S_PROG_HI: st_d = S_POLL_INIT;
            S_POLL_INIT: st_d = dev.rdata[UFC_B_INIT_ST] ? S_WAIT : S_POLL_INIT; // see [RQ3]
            S_SHIFT: st_d = (bit_q == 5'h1F && ctrl_q[1]) ? S_FLUSH_WR : S_SHIFT;
            S_FLUSH_WR: st_d = S_FLUSH_RD;
            S_FLUSH_RD: st_d = dev.rdata[UFC_B_DONE] ? S_IDX : (fl_q == UFC_FLUSH_MAX ? S_IDLE : S_FLUSH_WR);
            S_IDX: st_d = S_CMD_SET;
            S_CMD_SET: st_d = S_CMD_CLR;
            S_CMD_CLR: st_d = S_FIFO;
            default: st_d = S_IDLE;
        endcase
    end

    // Sequencer: one outstanding device access at a time
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_q <= S_IDLE;
            req_q <= 1'b0;
            wait_q <= 8'h00;
            fl_q <= 6'h00;
        end
        else if (ce)
        begin
            req_q <= 1'b0;
            if (st_q == S_IDLE)
            begin
                fl_q <= 6'h00;
                if (wr_go && aw_q == UFC_H_CTRL && wd_q[0])
                    st_q <= S_MASK;
            end
            else if (st_q == S_WAIT)
            begin
                // Settling time after init is seen high
                wait_q <= wait_q + 8'h01;
                if (wait_q == 8'(UFC_WAIT_CYC - 1)) // see [RQ4]
                begin
                    wait_q <= 8'h00;
                    st_q <= S_SHIFT;
                end
            end
            else if (op_act && !busy_q && !req_q) // Busy rises an edge late; keep the request one pulse
                req_q <= 1'b1;
            else if (dev.ack)
            begin
                st_q <= st_d;
                if (st_q == S_FLUSH_WR)
                    fl_q <= fl_q + 6'h01; // see [RQ7]
            end
        end
    end

    // Outstanding flag set by the request, dropped by the answer
    always_ff @(posedge clk)
    begin
        if (srst)
            busy_q <= 1'b0;
        else if (ce)
        begin
            if (req_q)
                busy_q <= 1'b1;
            else if (dev.ack)
                busy_q <= 1'b0;
        end
    end
    assign dev.req_wr = req_q & op_wr;
    assign dev.req_rd = req_q & ~op_wr;
    assign dev.addr = op_addr;
    assign dev.wdata = op_data;

    // Bitstream word: loaded by software, shifted out MSB first
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            word_q <= 32'h00000000;
            pend_q <= 1'b0;
            bit_q <= 5'h00;
        end
        else if (ce)
        begin
            if (st_q == S_SHIFT && dev.ack)
            begin
                word_q <= {word_q[30:0], 1'b0};
                bit_q <= bit_q + 5'h01;
                if (bit_q == 5'h1F)
                    pend_q <= 1'b0;
            end
            else if (wr_go && aw_q == UFC_H_DATA && !pend_q)
            begin
                word_q <= wd_q;
                pend_q <= 1'b1;
            end
        end
    end

    // Events: bit 0 configured, bit 1 failed; write one to clear, set wins
    assign ev = {st_q == S_FLUSH_RD && dev.ack && st_d == S_IDLE, st_q == S_FIFO && dev.ack};
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ists_q <= 2'h0;
            imsk_q <= 2'h0;
        end
        else if (ce)
        begin
            if (wr_go && aw_q == UFC_H_ISTS)
                ists_q <= (ists_q & ~wd_q[1:0]) | ev;
            else
                ists_q <= ists_q | ev;
            if (wr_go && aw_q == UFC_H_IMSK)
                imsk_q <= wd_q[1:0];
        end
    end
    assign irq = |(ists_q & imsk_q);
endmodule

// ===== ufc_sva.sv
`timescale 1ns/1ps
module ufc_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Device port
    input wire logic req_wr,
    input wire logic req_rd,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic ack,
    input wire logic host_irq
);
    import ufc_pkg::*;
    logic gie_q;
    logic clk_wr;
    logic any_req;
    // Last global enable sent to config; sampled at the take edge
    always_ff @(posedge clk)
    begin
        if (srst)
            gie_q <= 1'b0;
        else if (req_wr && addr == UFC_CFG_OFS)
            gie_q <= wdata[UFC_B_GIE];
    end
    // Clocked bit writes are the only slow writes
    assign clk_wr = req_wr && addr == UFC_CFG_OFS && wdata[UFC_B_CCLK_EN];
    assign any_req = req_wr || req_rd;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    ack_one_cycle_a: assert property (ack |=> !ack)
        else $error("ack held longer than one cycle");
    plain_wr_ack_a: assert property (req_wr && !clk_wr |=> ack)
        else $error("plain write not answered next cycle");
    clk_wr_ack_a: assert property (clk_wr |=> !ack [*3] ##1 ack)
        else $error("clocked write not answered after four cycles");
    clk_wr_held_a: assert property (clk_wr |=> ($stable(addr) && $stable(wdata)) [*3])
        else $error("clocked write payload changed before ack");
    ack_cause_a: assert property (ack |-> $past(any_req) || $past(any_req, 3) || $past(clk_wr, 4))
        else $error("ack without a request");
    unused_zero_a: assert property (req_rd && addr == UFC_CFG_OFS |=> ack && (rdata & 32'hFFC03E80) == 32'h0)
        else $error("unused config bits read nonzero");
    req_spacing_a: assert property (any_req |=> !any_req)
        else $error("requests back to back");
    prog_init_a: assert property (req_wr && addr == UFC_CFG_OFS && !wdata[UFC_B_PROG] |-> !wdata[UFC_B_INIT])
        else $error("program lowered without init");
    gie_gate_a: assert property (!gie_q && !$past(gie_q) && !$past(gie_q, 2) |-> !host_irq)
        else $error("host interrupt without global enable");
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    import ufc_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic init_i = 1'b0, done_i = 1'b0, uirq_i = 1'b0, dma_irq = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, word_q = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, cclk_q = 1'b0, flush_zero = 1'b0;
    logic prog_o, init_o, init_oe_n, cclk_o, din_o, fifo_en, ureg_wr, ureg_rd;
    logic [1:0] bresp, rresp;
    logic [6:0] ureg_addr;
    logic [7:0] ureg_wdata;
    logic [15:0] uw_q = 16'h0;
    int n_mismatch = 0, compares = 0, cyc = 0, n_cclk = 0, base = 0, done_at = -1, t_init = 0, t_cclk = 0;
    // 50 MHz
    always #10 clk = ~clk;
    ufc_if bus_if (.clk(clk));
    ufc_dev ufc_dev_inst (.clk(clk), .srst(srst), .ce(1'b1), .bus(bus_if), .prog_o(prog_o), .init_o(init_o),
        .init_oe_n(init_oe_n), .init_i(init_i), .done_i(done_i), .cclk_o(cclk_o), .din_o(din_o),
        .uirq_i(uirq_i), .dma_irq(dma_irq), .fifo_en(fifo_en), .ureg_addr(ureg_addr), .ureg_wr(ureg_wr),
        .ureg_rd(ureg_rd), .ureg_wdata(ureg_wdata), .ureg_rdata_i(8'hA5));
    ufc_host ufc_host_inst (.clk(clk), .srst(srst), .ce(1'b1), .dev(bus_if), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq));
    ufc_sva ufc_sva_inst (.clk(clk), .srst(srst), .req_wr(bus_if.req_wr), .req_rd(bus_if.req_rd),
        .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .ack(bus_if.ack),
        .host_irq(bus_if.host_irq));
    // User FPGA stand-in: init released once both pins free, done after done_at pulses
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        cclk_q <= cclk_o;
        init_i <= init_oe_n && prog_o;
        if (!init_i && init_oe_n && prog_o)
            t_init <= cyc;
        if (!prog_o)
            done_i <= 1'b0;
        else if (n_cclk == done_at)
            done_i <= 1'b1;
        if (cclk_o && !cclk_q)
        begin
            n_cclk <= n_cclk + 1;
            if (n_cclk < base + 32)
                word_q <= {word_q[30:0], din_o};
            if (n_cclk == base)
                t_cclk <= cyc;
            if (n_cclk >= base + 32 && !din_o)
                flush_zero <= 1'b1;
        end
        if (ureg_wr)
            uw_q <= {uw_q[7:0], ureg_wdata};
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic ha, hw, hb;
        hb = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!hb)
        begin
            @(negedge clk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid;
            @(posedge clk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (hb) bready <= 1'b0;
        end
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ha, hr;
        hr = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!hr)
        begin
            @(negedge clk);
            ha = arvalid && arready;
            hr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ha) arvalid <= 1'b0;
            if (hr) rready <= 1'b0;
        end
    endtask
    // Poll the controller until a configure run reports
    task automatic wait_ists(output logic [31:0] v);
        logic [1:0] r;
        for (int n = 0; n < 3000; n++)
        begin
            axi_rd(UFC_H_ISTS, v, r);
            if (v !== 32'h0) break;
        end
    endtask
    task automatic t_reset();
        logic [31:0] v;
        logic [1:0] r;
        axi_rd(UFC_H_STAT, v, r);
        chk("stat", 32'h0, v);
        axi_rd(8'h14, v, r);
        chk("unmapped_resp", {30'h0, UFC_RESP_ERR}, {30'h0, r});
        chk("unmapped_data", 32'h0, v);
    endtask
    task automatic t_config_ok(input logic [31:0] c);
        logic [31:0] v;
        logic [1:0] r;
        base = n_cclk;
        done_at = n_cclk + 34;
        axi_wr(UFC_H_DATA, 32'hC3A55A3C);
        axi_wr(UFC_H_CTRL, c);
        wait_ists(v);
        chk("ists_ok", 32'h1, v);
        chk("bitstream", 32'hC3A55A3C, word_q);
        chk("flush_ones", 32'h0, {31'h0, flush_zero});
        chk("init_wait", 32'h1, {31'h0, (t_cclk - t_init) >= 200});
        chk("prog_pin", 32'h1, {31'h0, prog_o});
        chk("init_free", 32'h1, {31'h0, init_oe_n});
        chk("fifo_en", 32'h1, {31'h0, fifo_en});
        chk("cmd_pulse", 32'h0800, {16'h0, uw_q});
        chk("index", 32'h0, {25'h0, ureg_addr});
        axi_wr(UFC_H_ISTS, 32'h1);
        axi_rd(UFC_H_ISTS, v, r);
        chk("ists_clr", 32'h0, v);
    endtask
    task automatic t_config_fail();
        logic [31:0] v;
        base = n_cclk;
        done_at = -1;
        axi_wr(UFC_H_DATA, 32'h0000FFFF);
        axi_wr(UFC_H_CTRL, 32'h3);
        wait_ists(v);
        chk("ists_fail", 32'h2, v);
        chk("pulses", 32'd64, n_cclk - base);
        axi_wr(UFC_H_IMSK, 32'h0);
        @(negedge clk);
        chk("irq_masked", 32'h0, {31'h0, irq});
        axi_wr(UFC_H_IMSK, 32'h2);
        @(negedge clk);
        chk("irq_on", 32'h1, {31'h0, irq});
        axi_wr(UFC_H_ISTS, 32'h2);
        @(negedge clk);
        chk("irq_clr", 32'h0, {31'h0, irq});
    endtask
    // Enables reach the device only through a configure run
    task automatic t_irq();
        logic [31:0] v;
        logic [1:0] r;
        t_config_ok(32'h7);
        @(posedge clk);
        uirq_i <= 1'b1;
        dma_irq <= 1'b1;
        repeat (4) @(posedge clk);
        uirq_i <= 1'b0;
        dma_irq <= 1'b0;
        repeat (10) @(posedge clk);
        axi_rd(UFC_H_STAT, v, r);
        chk("irq_no_gie", 32'h0, {31'h0, v[2]});
        t_config_ok(32'hF);
        for (int n = 0; n < 20 && v[2] !== 1'b1; n++)
            axi_rd(UFC_H_STAT, v, r);
        chk("irq_gie", 32'h1, {31'h0, v[2]});
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #1500000;
        n_mismatch++;
        summarize();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_config_ok(32'h3);
        t_config_fail();
        t_irq();
        summarize();
    end
endmodule
